// ===== tpc_panel.sv
// Overview of operation
// - self-test mode suppresses all transmissions
// - self-test lights every segment four seconds first
// - no fault: TEST, OK, pass voice
// - fault: standby annunciation; external fault, none critical: check voice
// - fault shown as F, primary, two-digit secondary
// - any critical fault plays test-fail voice
// - several faults cycle through code field repeatedly
// - cleared faults drop out; none left: OK
// - preset in test shows four revisions, 4s each
// - external ident acts exactly like panel ident
// - never send SPI on Mode C replies
// - ON/altitude ident: SPI, status, ME, lamp 18s
// - ground ident: discrete status flag, lamp 18s
// - new code saved and used 3.5s later
// - ident during entry adopts code at once
// - power-up restores last active squawk code
// - brief preset press outside standby and test adopts and saves preset code
// - preset overwritten only in standby, ident held
// - 2s preset hold reverts, active 3.5s later
// - reply lamp twice/s Mode S, once/s ATCRBS
// - altitude mode shows flight level or dashes
// - faults carry class, secondary code, criticality
// - altitude valid only -1000 to 62749 ft
`timescale 1ns/1ps
module tpc_panel #(
    parameter int unsigned TICK_CYCLES = tpc_pkg::TICK_CYC
) (
    input wire logic SYS_CLK, // 20 MHz clock
    input wire logic RSTN, // sync reset, low
    input wire logic [2:0] MODE_SEL, // mode selector
    input wire logic IDENT_BTN, // panel ident, high pressed
    input wire logic EXT_IDENT, // rear ident, high pressed
    input wire logic PRESET_BTN, // preset code button, high pressed
    input wire logic [11:0] KNOB_CODE, // knob octal digits
    input wire logic KNOB_DONE, // pulse: entry finished
    input wire logic [11:0] NV_LAST_CODE, // stored last code
    input wire logic [11:0] NV_PRESET_CODE, // stored preset code
    input wire logic [31:0] FAULT_ACTIVE, // fault monitor flags
    input wire logic [63:0] REV_CODES, // application_revision_label, boot, firmware_revision_label, voice revs
    input wire logic REPLY_MODE_S, // pulse: Mode S reply sent
    input wire logic REPLY_ATCRBS, // pulse: ATCRBS reply sent
    input wire logic ALT_PRESENT, // altitude source present
    input wire logic ALT_VALID, // source says valid
    input wire logic signed [16:0] ALT_FEET, // altitude, feet
    output logic TX_INHIBIT, // suppress all transmissions
    output logic SPI_MODE_A, // add SPI to Mode A replies only
    output logic FS_IDENT, // ident in formats 4 and 5 status
    output logic FS_DISCRETE_ONLY, // status ident on discrete only
    output logic ME_IDENT, // ident in format 17 ME
    output logic IDENT_LAMP, // ident annunciator
    output logic [11:0] ACTIVE_CODE, // squawk used in replies
    output logic NV_WR, // pulse: write non-volatile
    output logic NV_PRESET_SEL, // write target: 1 preset, 0 last
    output logic [11:0] NV_DATA, // data for write
    output logic LAMP_TEST, // all segments on
    output logic [3:0] ALT_SHOW, // altitude field content
    output logic signed [9:0] ALT_FL, // flight level, hundreds ft
    output logic FL_MARKER, // flight level marker
    output logic [1:0] CODE_SHOW, // code field content
    output logic [15:0] CODE_DIGITS, // code field nibbles
    output logic VOICE_PLAY, // pulse: start message
    output logic [1:0] VOICE_MSG, // message select
    output logic REPLY_LAMP // reply indicator
);
    logic tick;
    tpc_flt_if flt ();
    assign flt.active = FAULT_ACTIVE;
    tpc_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (.clk(SYS_CLK), .rst_n(RSTN), .tick(tick));
    tpc_fault_scan u_scan (.clk(SYS_CLK), .rst_n(RSTN), .tick(tick), .f(flt));

    // mode decode
    wire m_test = (MODE_SEL == tpc_pkg::MODE_TEST);
    wire m_sby = (MODE_SEL == tpc_pkg::MODE_SBY);
    wire m_gnd = (MODE_SEL == tpc_pkg::MODE_GND);
    wire m_onalt = (MODE_SEL == tpc_pkg::MODE_ON) || (MODE_SEL == tpc_pkg::MODE_ALT);
    wire m_alt = (MODE_SEL == tpc_pkg::MODE_ALT);

    // button edges
    logic idt_d_reg;
    logic pre_d_reg;
    wire idt_lvl = IDENT_BTN | EXT_IDENT;
    wire idt_rise = idt_lvl & ~idt_d_reg;
    wire pre_rise = PRESET_BTN & ~pre_d_reg;
    wire pre_fall = ~PRESET_BTN & pre_d_reg;

    // squawk state
    logic restored_reg;
    logic [11:0] disp_code_reg;
    logic [11:0] preset_reg;
    logic [11:0] nonpreset_reg;
    logic pend_reg;
    logic [7:0] pend_cnt_reg;
    logic [7:0] hold_cnt_reg;
    logic hold_used_reg;
    wire prog_preset = pre_rise & m_sby & idt_lvl;
    wire brief_pre = pre_fall & ~hold_used_reg & ~m_test & ~m_sby;
    wire revert = PRESET_BTN & ~hold_used_reg & ~m_test & tick & (hold_cnt_reg == tpc_pkg::REVERT_TICKS - 8'h01);
    wire pend_due = pend_reg & tick & (pend_cnt_reg == tpc_pkg::CODE_TICKS - 8'h01);
    wire adopt_now = pend_reg & (pend_due | idt_rise);

    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            idt_d_reg <= 1'b0;
            pre_d_reg <= 1'b0;
            hold_cnt_reg <= 8'h00;
            hold_used_reg <= 1'b0;
        end
        else
        begin
            idt_d_reg <= idt_lvl;
            pre_d_reg <= PRESET_BTN;
            hold_cnt_reg <= !PRESET_BTN ? 8'h00 : (tick ? 8'(hold_cnt_reg + 8'h01) : hold_cnt_reg);
            hold_used_reg <= PRESET_BTN & (hold_used_reg | revert | prog_preset);
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            restored_reg <= 1'b0;
            disp_code_reg <= 12'h000;
            preset_reg <= 12'h000;
            nonpreset_reg <= 12'h000;
            ACTIVE_CODE <= 12'h000;
            pend_reg <= 1'b0;
            pend_cnt_reg <= 8'h00;
            NV_WR <= 1'b0;
            NV_PRESET_SEL <= 1'b0;
            NV_DATA <= 12'h000;
        end
        else
        begin
            NV_WR <= 1'b0;
            if (!restored_reg)
            begin
                restored_reg <= 1'b1;
                disp_code_reg <= NV_LAST_CODE;
                ACTIVE_CODE <= NV_LAST_CODE;
                nonpreset_reg <= NV_LAST_CODE;
                preset_reg <= NV_PRESET_CODE;
            end
            else if (prog_preset)
            begin
                preset_reg <= disp_code_reg;
                NV_WR <= 1'b1;
                NV_PRESET_SEL <= 1'b1;
                NV_DATA <= disp_code_reg;
            end
            else if (brief_pre)
            begin
                disp_code_reg <= preset_reg;
                ACTIVE_CODE <= preset_reg;
                pend_reg <= 1'b0;
                NV_WR <= 1'b1;
                NV_PRESET_SEL <= 1'b0;
                NV_DATA <= preset_reg;
            end
            else if (KNOB_DONE | revert)
            begin
                disp_code_reg <= KNOB_DONE ? KNOB_CODE : nonpreset_reg;
                nonpreset_reg <= KNOB_DONE ? KNOB_CODE : nonpreset_reg;
                pend_reg <= 1'b1;
                pend_cnt_reg <= 8'h00;
            end
            else if (adopt_now)
            begin
                ACTIVE_CODE <= disp_code_reg;
                pend_reg <= 1'b0;
                NV_WR <= 1'b1;
                NV_PRESET_SEL <= 1'b0;
                NV_DATA <= disp_code_reg;
            end
            else if (pend_reg & tick)
                pend_cnt_reg <= 8'(pend_cnt_reg + 8'h01);
        end
    end

    // ident period
    logic [7:0] ident_cnt_reg;
    wire ident_on = (ident_cnt_reg != 8'h00);
    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
            ident_cnt_reg <= 8'h00;
        else if (idt_rise & (m_gnd | m_onalt) & ~prog_preset)
            ident_cnt_reg <= tpc_pkg::IDENT_TICKS;
        else if (tick & ident_on)
            ident_cnt_reg <= 8'(ident_cnt_reg - 8'h01);
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            TX_INHIBIT <= 1'b1;
            SPI_MODE_A <= 1'b0;
            FS_IDENT <= 1'b0;
            FS_DISCRETE_ONLY <= 1'b0;
            ME_IDENT <= 1'b0;
            IDENT_LAMP <= 1'b0;
        end
        else
        begin
            TX_INHIBIT <= m_test | m_sby | (MODE_SEL == tpc_pkg::MODE_FLTID);
            SPI_MODE_A <= ident_on & m_onalt;
            FS_IDENT <= ident_on & (m_onalt | m_gnd);
            FS_DISCRETE_ONLY <= ident_on & m_gnd;
            ME_IDENT <= ident_on & m_onalt;
            IDENT_LAMP <= ident_on & (m_onalt | m_gnd);
        end
    end

    // self-test sequencer
    tpc_pkg::tpc_test_t ts_reg;
    logic [7:0] ts_cnt_reg;
    logic [1:0] rev_idx_reg;
    // full ticks counted, so a hold never falls short of its minimum
    wire ts_done = tick & (ts_cnt_reg == tpc_pkg::LAMP_TICKS);
    wire rev_done = tick & (ts_cnt_reg == tpc_pkg::REV_TICKS);
    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            ts_reg <= tpc_pkg::TS_IDLE;
            ts_cnt_reg <= 8'h00;
            rev_idx_reg <= 2'h0;
            VOICE_PLAY <= 1'b0;
            VOICE_MSG <= tpc_pkg::VOICE_PASS;
        end
        else
        begin
            VOICE_PLAY <= 1'b0;
            ts_cnt_reg <= tick ? 8'(ts_cnt_reg + 8'h01) : ts_cnt_reg;
            unique case (ts_reg)
                tpc_pkg::TS_IDLE:
                begin
                    ts_cnt_reg <= 8'h00;
                    if (m_test)
                        ts_reg <= tpc_pkg::TS_LAMP;
                end
                tpc_pkg::TS_LAMP:
                    if (ts_done)
                    begin
                        ts_reg <= tpc_pkg::TS_RESULT;
                        VOICE_PLAY <= ~flt.any | flt.crit | flt.ext;
                        VOICE_MSG <= flt.crit ? tpc_pkg::VOICE_FAIL :
                                     flt.any ? tpc_pkg::VOICE_CHECK : tpc_pkg::VOICE_PASS;
                    end
                tpc_pkg::TS_RESULT:
                    if (pre_rise)
                    begin
                        ts_reg <= tpc_pkg::TS_REV;
                        ts_cnt_reg <= 8'h00;
                        rev_idx_reg <= 2'h0;
                    end
                tpc_pkg::TS_REV:
                    if (rev_done)
                    begin
                        ts_cnt_reg <= 8'h00;
                        rev_idx_reg <= 2'(rev_idx_reg + 2'h1);
                        if (rev_idx_reg == 2'h3)
                            ts_reg <= tpc_pkg::TS_RESULT;
                    end
            endcase
            if (!m_test)
                ts_reg <= tpc_pkg::TS_IDLE;
        end
    end

    // display selection
    wire signed [16:0] fl_full = ALT_FEET / tpc_pkg::FT_PER_FL;
    wire alt_ok = ALT_PRESENT & ALT_VALID & (ALT_FEET >= tpc_pkg::ALT_MIN_FT) & (ALT_FEET <= tpc_pkg::ALT_MAX_FT);
    wire in_lamp = m_test & (ts_reg != tpc_pkg::TS_RESULT) & (ts_reg != tpc_pkg::TS_REV);
    wire in_rev = m_test & (ts_reg == tpc_pkg::TS_REV);
    wire in_res = m_test & (ts_reg == tpc_pkg::TS_RESULT);
    wire [3:0] rev_label = 4'(tpc_pkg::ALT_APPLICATION_REVISION_LABEL + 4'(rev_idx_reg));
    wire [15:0] rev_val = REV_CODES[63 - 16 * rev_idx_reg -: 16];
    wire [15:0] sq_dig = {1'b0, disp_code_reg[11:9], 1'b0, disp_code_reg[8:6],
                          1'b0, disp_code_reg[5:3], 1'b0, disp_code_reg[2:0]};
    logic [3:0] alt_sel;
    always_comb
    begin
        alt_sel = tpc_pkg::ALT_BLANK;
        if (in_rev)
            alt_sel = rev_label;
        else if (in_res)
            alt_sel = flt.any ? tpc_pkg::ALT_SBY : tpc_pkg::ALT_TEST;
        else if (m_sby)
            alt_sel = tpc_pkg::ALT_SBY;
        else if (m_gnd)
            alt_sel = tpc_pkg::ALT_GND;
        else if (m_alt)
            alt_sel = alt_ok ? tpc_pkg::ALT_LEVEL : tpc_pkg::ALT_DASH;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            LAMP_TEST <= 1'b0;
            ALT_SHOW <= tpc_pkg::ALT_BLANK;
            ALT_FL <= 10'sh000;
            FL_MARKER <= 1'b0;
            CODE_SHOW <= tpc_pkg::CODE_SQUAWK;
            CODE_DIGITS <= 16'h0000;
        end
        else
        begin
            LAMP_TEST <= in_lamp;
            ALT_SHOW <= alt_sel;
            ALT_FL <= fl_full[9:0];
            FL_MARKER <= m_alt;
            CODE_SHOW <= in_rev ? tpc_pkg::CODE_REV : ~in_res ? tpc_pkg::CODE_SQUAWK :
                         flt.any ? tpc_pkg::CODE_FAULT : tpc_pkg::CODE_OK;
            CODE_DIGITS <= in_rev ? rev_val : (in_res & flt.any) ? tpc_pkg::fault_digits(flt.idx) : sq_dig;
        end
    end

    // reply indicator: FLASH_TICKS phases per second
    logic [3:0] ph_reg;
    logic ms_seen_reg;
    logic ac_seen_reg;
    wire sec_end = tick & (ph_reg == tpc_pkg::FLASH_TICKS - 4'h1);
    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            ph_reg <= 4'h0;
            ms_seen_reg <= 1'b0;
            ac_seen_reg <= 1'b0;
            REPLY_LAMP <= 1'b0;
        end
        else
        begin
            ph_reg <= sec_end ? 4'h0 : (tick ? 4'(ph_reg + 4'h1) : ph_reg);
            ms_seen_reg <= REPLY_MODE_S | (ms_seen_reg & ~sec_end);
            ac_seen_reg <= REPLY_ATCRBS | (ac_seen_reg & ~sec_end);
            REPLY_LAMP <= ms_seen_reg ? (ph_reg == 4'h0 || ph_reg == tpc_pkg::FLASH_HALF) :
                          (ac_seen_reg & (ph_reg == 4'h0));
        end
    end

    chk_test_quiet: assert property (@(posedge SYS_CLK) disable iff (!RSTN) m_test |=> TX_INHIBIT)
        else $error("transmit not inhibited in test");
    chk_lamp_hold: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (ts_reg == tpc_pkg::TS_LAMP) ##1 (ts_reg == tpc_pkg::TS_RESULT) |-> $past(ts_cnt_reg) >= tpc_pkg::LAMP_TICKS)
        else $error("lamp test ended early");
    chk_fail_voice: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        VOICE_PLAY && VOICE_MSG == tpc_pkg::VOICE_FAIL |-> $past(flt.crit))
        else $error("fail message without critical fault");
    chk_pass_voice: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        VOICE_PLAY && VOICE_MSG == tpc_pkg::VOICE_PASS |-> !$past(flt.any))
        else $error("pass message with fault present");
    chk_spi_mode: assert property (@(posedge SYS_CLK) disable iff (!RSTN) SPI_MODE_A |-> $past(m_onalt && ident_on))
        else $error("spi outside on or altitude ident");
    chk_gnd_ident: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        FS_DISCRETE_ONLY |-> FS_IDENT && !SPI_MODE_A && !ME_IDENT)
        else $error("ground ident flags wrong");
    chk_code_delay: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        $past(restored_reg) && $changed(ACTIVE_CODE) |-> $past(pend_due || idt_rise || brief_pre))
        else $error("active code changed without cause");
    chk_alt_range: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        ALT_SHOW == tpc_pkg::ALT_LEVEL |-> $past(ALT_FEET) >= tpc_pkg::ALT_MIN_FT && $past(ALT_FEET) <= tpc_pkg::ALT_MAX_FT)
        else $error("flight level shown out of range");
endmodule

// ===== tpc_pkg.sv
package tpc_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    // second-scale periods in ms, counted in ticks
    localparam int unsigned LAMP_MS = 4000;
    localparam int unsigned REV_MS = 4000;
    localparam int unsigned IDENT_MS = 18000;
    localparam int unsigned CODE_DLY_MS = 3500;
    localparam int unsigned REVERT_MS = 2000;
    localparam int unsigned STEP_MS = 1000;
    localparam int unsigned FLASH_MS = 1000;
    localparam logic [7:0] LAMP_TICKS = 8'((LAMP_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [7:0] REV_TICKS = 8'((REV_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [7:0] IDENT_TICKS = 8'(IDENT_MS / TICK_MS);
    localparam logic [7:0] CODE_TICKS = 8'(CODE_DLY_MS / TICK_MS);
    localparam logic [7:0] REVERT_TICKS = 8'(REVERT_MS / TICK_MS);
    localparam logic [3:0] STEP_TICKS = 4'(STEP_MS / TICK_MS);
    localparam logic [3:0] FLASH_TICKS = 4'(FLASH_MS / TICK_MS);
    localparam logic [3:0] FLASH_HALF = 4'(FLASH_MS / TICK_MS / 2);
    // fault table layout: index bases of each primary class
    localparam int unsigned NFAULT = 32;
    localparam logic [4:0] BASE2 = 5'h04;
    localparam logic [4:0] BASE3 = 5'h08;
    localparam logic [4:0] BASE4 = 5'h18;
    localparam logic [4:0] BASE5 = 5'h19;
    localparam logic [4:0] BASE6 = 5'h1b;
    localparam int unsigned CRIT_LAST = 24;
    localparam int unsigned EXT_FIRST = 27;
    localparam logic [3:0] FAULT_LETTER = 4'hf;
    // flight level limits, feet
    localparam logic signed [16:0] ALT_MIN_FT = -17'sd1000;
    localparam logic signed [16:0] ALT_MAX_FT = 17'sd62749;
    localparam logic signed [16:0] FT_PER_FL = 17'sd100;

    typedef enum logic [2:0] {
        MODE_SBY = 3'h0, MODE_GND = 3'h1, MODE_ON = 3'h2,
        MODE_ALT = 3'h3, MODE_FLTID = 3'h4, MODE_TEST = 3'h5
    } tpc_mode_t;
    typedef enum logic [1:0] {
        TS_IDLE = 2'h0, TS_LAMP = 2'h1, TS_RESULT = 2'h2, TS_REV = 2'h3
    } tpc_test_t;
    typedef enum logic [3:0] {
        ALT_BLANK = 4'h0, ALT_TEST = 4'h1, ALT_SBY = 4'h2, ALT_GND = 4'h3,
        ALT_DASH = 4'h4, ALT_LEVEL = 4'h5, ALT_APPLICATION_REVISION_LABEL = 4'h6, ALT_BOOT = 4'h7,
        ALT_FIRMWARE_REVISION_LABEL = 4'h8, ALT_VOICE_REVISION_LABEL = 4'h9
    } tpc_alt_t;
    typedef enum logic [1:0] {
        CODE_SQUAWK = 2'h0, CODE_OK = 2'h1, CODE_FAULT = 2'h2, CODE_REV = 2'h3
    } tpc_code_t;
    typedef enum logic [1:0] {
        VOICE_PASS = 2'h0, VOICE_CHECK = 2'h1, VOICE_FAIL = 2'h2
    } tpc_voice_t;

    // fault_display_format digits: F, primary, secondary tens, ones
    function automatic logic [15:0] fault_digits(input logic [4:0] idx);
        logic [3:0] pri;
        logic [4:0] base;
        logic [4:0] sec;
        pri = 4'h6;
        base = BASE6;
        if (idx < BASE2) begin pri = 4'h1; base = 5'h00; end
        else if (idx < BASE3) begin pri = 4'h2; base = BASE2; end
        else if (idx < BASE4) begin pri = 4'h3; base = BASE3; end
        else if (idx < BASE5) begin pri = 4'h4; base = BASE4; end
        else if (idx < BASE6) begin pri = 4'h5; base = BASE5; end
        sec = 5'(idx - base + 5'h01);
        return {FAULT_LETTER, pri, 4'(sec / 5'd10), 4'(sec % 5'd10)};
    endfunction
endpackage

// ===== tpc_flt_if.sv
`timescale 1ns/1ps
interface tpc_flt_if;
    logic [31:0] active;
    logic [4:0] idx;
    logic any;
    logic crit;
    logic ext;
    modport scan (input active, output idx, any, crit, ext);
    modport user (output active, input idx, any, crit, ext);
endinterface

// ===== tpc_tick.sv
`timescale 1ns/1ps
module tpc_tick #(
    parameter int unsigned TICK_CYCLES = tpc_pkg::TICK_CYC
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // sync reset
    output logic tick // one-cycle pulse per tick
);
    localparam int unsigned W = $clog2(TICK_CYCLES + 1);
    logic [W-1:0] cnt_reg;
    wire wrap = (cnt_reg == W'(TICK_CYCLES - 1));

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt_reg <= wrap ? '0 : W'(cnt_reg + 1'b1);
            tick <= wrap;
        end
    end
endmodule

// ===== tpc_fault_scan.sv
`timescale 1ns/1ps
module tpc_fault_scan (
    input wire logic clk, // system clock
    input wire logic rst_n, // sync reset
    input wire logic tick, // timebase pulse
    tpc_flt_if.scan f // fault status carrier
);
    logic [4:0] idx_reg;
    logic [3:0] dwell_reg;
    logic [4:0] nxt;
    wire cur_ok = f.active[idx_reg];

    // next active entry after the shown one, wrapping
    always_comb
    begin
        nxt = idx_reg;
        for (int i = 32; i >= 1; i--)
        begin
            if (f.active[5'(idx_reg + 5'(i))])
                nxt = 5'(idx_reg + 5'(i));
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            idx_reg <= 5'h00;
            dwell_reg <= 4'h0;
        end
        else if (!cur_ok)
        begin
            idx_reg <= nxt;
            dwell_reg <= 4'h0;
        end
        else if (tick)
        begin
            idx_reg <= (dwell_reg == tpc_pkg::STEP_TICKS - 4'h1) ? nxt : idx_reg;
            dwell_reg <= (dwell_reg == tpc_pkg::STEP_TICKS - 4'h1) ? 4'h0 : 4'(dwell_reg + 4'h1);
        end
    end

    assign f.idx = idx_reg;
    assign f.any = |f.active;
    assign f.crit = |f.active[tpc_pkg::CRIT_LAST:0];
    assign f.ext = |f.active[31:tpc_pkg::EXT_FIRST];
endmodule

// ===== tpc_far_model.sv
`timescale 1ns/1ps
module tpc_far_model #(
    parameter logic [11:0] LAST_INIT = 12'h29c,
    parameter logic [11:0] PRESET_INIT = 12'h0b6
) (
    input wire logic clk, // system clock
    input wire logic nv_wr, // write strobe
    input wire logic nv_preset_sel, // 1 preset, 0 last
    input wire logic [11:0] nv_data, // write data
    output logic [11:0] last_code, // stored last code
    output logic [11:0] preset_code // stored preset code
);
    initial last_code = LAST_INIT;
    initial preset_code = PRESET_INIT;
    // non-volatile store keeps codes across resets
    always @(posedge clk)
    begin
        if (nv_wr && nv_preset_sel)
            preset_code <= nv_data;
        else if (nv_wr)
            last_code <= nv_data;
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 0, rstn = 0, idb = 0, exid = 0, pre = 0, kdone = 0, ap = 0, av = 0, rms = 0, rac = 0;
    logic [2:0] mode = 3'h2;
    logic [11:0] knob = 12'h000, lastc, prec;
    logic [31:0] flt = 32'h0;
    logic signed [16:0] feet = 17'sh0;
    logic [1:0] voice = 2'h3;
    logic [15:0] a, b;
    int num_errors = 0, total_checks = 0;
    wire txi, spi, fsi, fsd, mei, il, nvw, nvs, lt, fm, vp, rl;
    wire [11:0] act, nvd;
    wire [3:0] alts;
    wire signed [9:0] fl;
    wire [1:0] cs, vm;
    wire [15:0] cd;
    always #25 clk = ~clk;
    always @(posedge clk) if (vp) voice <= vm;
    tpc_far_model u_far (.clk(clk), .nv_wr(nvw), .nv_preset_sel(nvs), .nv_data(nvd),
        .last_code(lastc), .preset_code(prec));
    tpc_panel #(.TICK_CYCLES(10)) u_dut (.SYS_CLK(clk), .RSTN(rstn), .MODE_SEL(mode), .IDENT_BTN(idb),
        .EXT_IDENT(exid), .PRESET_BTN(pre), .KNOB_CODE(knob), .KNOB_DONE(kdone), .NV_LAST_CODE(lastc),
        .NV_PRESET_CODE(prec), .FAULT_ACTIVE(flt), .REV_CODES(64'h1234_5678_9abc_def0), .REPLY_MODE_S(rms),
        .REPLY_ATCRBS(rac), .ALT_PRESENT(ap), .ALT_VALID(av), .ALT_FEET(feet), .TX_INHIBIT(txi),
        .SPI_MODE_A(spi), .FS_IDENT(fsi), .FS_DISCRETE_ONLY(fsd), .ME_IDENT(mei), .IDENT_LAMP(il),
        .ACTIVE_CODE(act), .NV_WR(nvw), .NV_PRESET_SEL(nvs), .NV_DATA(nvd), .LAMP_TEST(lt), .ALT_SHOW(alts),
        .ALT_FL(fl), .FL_MARKER(fm), .CODE_SHOW(cs), .CODE_DIGITS(cd), .VOICE_PLAY(vp), .VOICE_MSG(vm),
        .REPLY_LAMP(rl));
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            num_errors++;
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task knob_entry;
        knob = 12'h1ff;
        kdone = 1;
        cyc(1);
        kdone = 0;
        cyc(300);
        check(act, 12'h29c);
        cyc(100);
        check(act, 12'h1ff);
        check(lastc, 12'h1ff);
    endtask
    task ident_during_entry;
        knob = 12'h0a4;
        kdone = 1;
        cyc(1);
        kdone = 0;
        exid = 1;
        cyc(4);
        exid = 0;
        check(act, 12'h0a4);
        check({spi, fsi, mei, il, fsd}, 5'h1e);
        cyc(1650);
        check(il, 1'b1);
        cyc(200);
        check({spi, fsi, mei, il}, 4'h0);
    endtask
    task ground_ident;
        mode = 3'h1;
        cyc(2);
        idb = 1;
        cyc(4);
        idb = 0;
        check({spi, fsi, fsd, il}, 4'h7);
    endtask
    task preset_press;
        mode = 3'h2;
        pre = 1;
        cyc(3);
        pre = 0;
        cyc(3);
        check(act, 12'h0b6);
        check(lastc, 12'h0b6);
    endtask
    task altitude_show;
        mode = 3'h3;
        {ap, av, feet} = {2'b11, 17'sd4000};
        cyc(3);
        check({alts, fm}, {tpc_pkg::ALT_LEVEL, 1'b1});
        check(fl, 10'sd40);
        feet = 17'sd62750;
        cyc(3);
        check(alts, tpc_pkg::ALT_DASH);
    endtask
    task preset_revert;
        pre = 1;
        cyc(210);
        pre = 0;
        check({cd, act}, {16'h0244, 12'h0b6});
        cyc(290);
        check(act, 12'h0b6);
        cyc(60);
        check(act, 12'h0a4);
    endtask
    task preset_program;
        mode = 3'h0;
        knob = 12'h765;
        kdone = 1;
        cyc(1);
        kdone = 0;
        idb = 1;
        cyc(1);
        pre = 1;
        cyc(2);
        {pre, idb} = 2'b00;
        cyc(2);
        check(prec, 12'h765);
    endtask
    task reply_lamp(input logic s, input int n);
        logic prev;
        int rises;
        rises = 0;
        rms = s;
        rac = ~s;
        cyc(200);
        prev = rl;
        repeat (100)
        begin
            cyc(1);
            if (rl & ~prev)
                rises++;
            prev = rl;
        end
        check(rises, n);
    endtask
    task revisions;
        pre = 1;
        cyc(2);
        pre = 0;
        cyc(1);
        check({alts, cs, cd}, {tpc_pkg::ALT_APPLICATION_REVISION_LABEL, tpc_pkg::CODE_REV, 16'h1234});
        cyc(395);
        check(alts, tpc_pkg::ALT_APPLICATION_REVISION_LABEL);
        cyc(20);
        check({alts, cd}, {tpc_pkg::ALT_BOOT, 16'h5678});
        cyc(410);
        check({alts, cd}, {tpc_pkg::ALT_FIRMWARE_REVISION_LABEL, 16'h9abc});
        cyc(410);
        check({alts, cd}, {tpc_pkg::ALT_VOICE_REVISION_LABEL, 16'hdef0});
    endtask
    task self_test(input logic [31:0] f);
        mode = 3'h0;
        flt = f;
        voice = 2'h3;
        cyc(3);
        mode = 3'h5;
        cyc(3);
        check({txi, lt}, 2'b11);
        cyc(370);
        check(lt, 1'b1);
        cyc(80);
        check(lt, 1'b0);
    endtask
    initial
    begin
        cyc(8);
        rstn = 1;
        cyc(3);
        check(act, 12'h29c);
        knob_entry();
        ident_during_entry();
        ground_ident();
        preset_press();
        preset_revert();
        altitude_show();
        preset_program();
        reply_lamp(1'b1, 2);
        reply_lamp(1'b0, 1);
        rac = 0;
        self_test(32'h0);
        check({alts, cs, voice}, {tpc_pkg::ALT_TEST, tpc_pkg::CODE_OK, tpc_pkg::VOICE_PASS});
        self_test(32'h1000_0008);
        check({alts, cs, voice}, {tpc_pkg::ALT_SBY, tpc_pkg::CODE_FAULT, tpc_pkg::VOICE_FAIL});
        a = cd;
        cyc(100);
        b = cd;
        check(a ^ b, 16'hf104 ^ 16'hf602);
        flt = 32'h0;
        cyc(30);
        check({alts, cs}, {tpc_pkg::ALT_TEST, tpc_pkg::CODE_OK});
        revisions();
        end_of_test();
    end
    initial
    begin
        #1_000_000;
        num_errors++;
        end_of_test();
    end
endmodule
